// >>> include/psc_params.svh
// timing constants and widths for the pseudo sram access controller
`ifndef PSC_PARAMS_SVH
`define PSC_PARAMS_SVH
`define PSC_CLK_PERIOD_PS 4000
`define PSC_PWRUP_US 100
`define PSC_PWRUP_CYC ((`PSC_PWRUP_US * 1000000) / `PSC_CLK_PERIOD_PS)
`define PSC_CYCLE_NS 70
`define PSC_CYCLE_CYC \
    ((`PSC_CYCLE_NS * 1000 + `PSC_CLK_PERIOD_PS - 1) / `PSC_CLK_PERIOD_PS)
`define PSC_WP_NS 55
`define PSC_WP_CYC \
    ((`PSC_WP_NS * 1000 + `PSC_CLK_PERIOD_PS - 1) / `PSC_CLK_PERIOD_PS)
`define PSC_ACC_NS 70
`define PSC_ACC_CYC \
    ((`PSC_ACC_NS * 1000 + `PSC_CLK_PERIOD_PS - 1) / `PSC_CLK_PERIOD_PS)
`define PSC_SYNC_CYC 2
`define PSC_ADDR_W 20
`define PSC_DATA_W 16
`define PSC_CNT_W 8
`define PSC_PWR_W 16
`endif

// >>> include/psc_pkg.sv
// types for the pseudo sram access controller
package psc_pkg;
    typedef enum logic [2:0] {
        PSC_POWERUP,
        PSC_IDLE,
        PSC_READ,
        PSC_WRITE,
        PSC_RECOVER
    } psc_state_e;
endpackage

// >>> logic/psc_wait_timer.sv
// loadable down counter used for the power-up wait
`timescale 1ns/10ps
`include "psc_params.svh"
module psc_wait_timer #(
    parameter int WIDTH = 8
) (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic enable_in,
    input wire logic load_in,
    input wire logic [WIDTH-1:0] value_in,
    output logic done_out
);
    logic [WIDTH-1:0] count_r;
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            count_r <= '0;
        end else if (enable_in) begin
            if (load_in) begin
                count_r <= value_in;
            end else if (count_r != '0) begin
                count_r <= count_r - 1'b1;
            end
        end
    end
    assign done_out = (count_r == '0);
endmodule

// >>> logic/psc_host_ctrl.sv
// host-side controller driving the pseudo sram control pins
`timescale 1ns/10ps
`include "psc_params.svh"
// Contract
// - hold primary select high 100 us after power
// - read: select low, oe low, we high
// - never cycle faster than 70 ns
// - one lane for byte, both for word
// - last asserted strobe opens write window
module psc_host_ctrl
    import psc_pkg::*;
#(
    parameter int PWRUP_CYCLES = `PSC_PWRUP_CYC
) (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic enable_in,
    input wire logic req_valid_in,
    input wire logic req_write_in,
    input wire logic [`PSC_ADDR_W-1:0] req_addr_in,
    input wire logic [`PSC_DATA_W-1:0] req_wdata_in,
    input wire logic [1:0] req_lane_in,
    output logic req_ready_out,
    output logic rd_valid_out,
    output logic [`PSC_DATA_W-1:0] rd_data_out,
    output logic mem_ready_out,
    output logic primary_select_n_out,
    output logic secondary_select_out,
    output logic output_enable_n_out,
    output logic write_strobe_n_out,
    output logic upper_lane_select_n_out,
    output logic lower_lane_select_n_out,
    output logic [`PSC_ADDR_W-1:0] addr_out,
    output logic [`PSC_DATA_W-1:0] dq_out,
    output logic dq_oe_out,
    input wire logic [`PSC_DATA_W-1:0] dq_in
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        psc_state_e state;
        logic [`PSC_CNT_W-1:0] cnt;
        logic ready;
        logic rd_valid;
        logic [`PSC_DATA_W-1:0] rd_data;
        logic mem_ready;
        logic sel_n;
        logic oe_n;
        logic we_n;
        logic ub_n;
        logic lb_n;
        logic [`PSC_ADDR_W-1:0] addr;
        logic [`PSC_DATA_W-1:0] dq;
        logic dq_oe;
        logic [`PSC_CNT_W-1:0] gap;
        logic [`PSC_DATA_W-1:0] dq_meta;
        logic [`PSC_DATA_W-1:0] dq_sync;
    } psc_regs_s;

    // idle pins, secondary low, wait timer not yet loaded
    localparam psc_regs_s REGS_RST = '{
        state: PSC_POWERUP,
        cnt: '0,
        ready: 1'b0,
        rd_valid: 1'b0,
        rd_data: '0,
        mem_ready: 1'b0,
        sel_n: 1'b1,
        oe_n: 1'b1,
        we_n: 1'b1,
        ub_n: 1'b1,
        lb_n: 1'b1,
        addr: '0,
        dq: '0,
        dq_oe: 1'b0,
        gap: '1,
        dq_meta: '0,
        dq_sync: '0
    };
    // next take lands two edges after the recover check
    localparam logic [`PSC_CNT_W-1:0] GAP_MIN =
        `PSC_CNT_W'(`PSC_CYCLE_CYC - 2);

    psc_regs_s regs_r;
    psc_regs_s regs_nxt;
    logic pwr_done;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [1:0] psc_lanes_n(input logic [1:0] lanes);
        // an empty lane mask is taken as a full word
        psc_lanes_n = (lanes == 2'h0) ? 2'h0 : ~lanes;
    endfunction

    // ------------------------------------------------------------
    // power-up wait
    // ------------------------------------------------------------
    psc_wait_timer #(.WIDTH(`PSC_PWR_W)) u_pwr_timer (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .enable_in(enable_in),
        .load_in(regs_r.state == PSC_POWERUP && !regs_r.mem_ready &&
                 regs_r.cnt == '0),
        .value_in(PWRUP_CYCLES[`PSC_PWR_W-1:0]),
        .done_out(pwr_done)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        regs_nxt = regs_r;
        regs_nxt.rd_valid = 1'b0;
        regs_nxt.dq_meta = dq_in;
        regs_nxt.dq_sync = regs_r.dq_meta;
        // cycles since the last select fall, held at its ceiling
        if (regs_r.gap != '1) begin
            regs_nxt.gap = regs_r.gap + 1'b1;
        end
        if (regs_r.cnt != '0 && regs_r.state != PSC_POWERUP) begin
            regs_nxt.cnt = regs_r.cnt - 1'b1;
        end
        case (regs_r.state)
            PSC_POWERUP: begin
                regs_nxt.sel_n = 1'b1;
                if (regs_r.cnt == '0) begin
                    regs_nxt.cnt = `PSC_CNT_W'h1;
                end else if (pwr_done) begin
                    regs_nxt.state = PSC_IDLE;
                    regs_nxt.mem_ready = 1'b1;
                    regs_nxt.ready = 1'b1;
                    regs_nxt.cnt = '0;
                end
            end
            PSC_IDLE: begin
                if (req_valid_in && regs_r.ready) begin
                    regs_nxt.ready = 1'b0;
                    regs_nxt.gap = '0;
                    regs_nxt.addr = req_addr_in;
                    regs_nxt.sel_n = 1'b0;
                    {regs_nxt.ub_n, regs_nxt.lb_n} =
                        psc_lanes_n(req_lane_in);
                    if (req_write_in) begin
                        // select, lanes and we fall on one edge
                        regs_nxt.dq = req_wdata_in;
                        regs_nxt.dq_oe = 1'b1;
                        regs_nxt.oe_n = 1'b1;
                        regs_nxt.we_n = 1'b0;
                        regs_nxt.cnt = `PSC_CNT_W'(`PSC_WP_CYC);
                        regs_nxt.state = PSC_WRITE;
                    end else begin
                        regs_nxt.oe_n = 1'b0;
                        regs_nxt.we_n = 1'b1;
                        // extra cycles let read data pass the synchroniser
                        regs_nxt.cnt =
                            `PSC_CNT_W'(`PSC_ACC_CYC + `PSC_SYNC_CYC);
                        regs_nxt.state = PSC_READ;
                    end
                end
            end
            PSC_READ: begin
                if (regs_r.cnt == '0) begin
                    regs_nxt.rd_data = regs_r.dq_sync;
                    regs_nxt.rd_valid = 1'b1;
                    regs_nxt.oe_n = 1'b1;
                    regs_nxt.sel_n = 1'b1;
                    regs_nxt.ub_n = 1'b1;
                    regs_nxt.lb_n = 1'b1;
                    regs_nxt.cnt = `PSC_CNT_W'h1;
                    regs_nxt.state = PSC_RECOVER;
                end
            end
            PSC_WRITE: begin
                if (regs_r.cnt == '0) begin
                    // we rises first and closes the window
                    regs_nxt.we_n = 1'b1;
                    regs_nxt.cnt = `PSC_CNT_W'h1;
                    regs_nxt.state = PSC_RECOVER;
                end
            end
            PSC_RECOVER: begin
                // hold data one cycle past the window close
                regs_nxt.dq_oe = 1'b0;
                regs_nxt.sel_n = 1'b1;
                regs_nxt.ub_n = 1'b1;
                regs_nxt.lb_n = 1'b1;
                if (regs_r.cnt == '0 && regs_r.gap >= GAP_MIN) begin
                    regs_nxt.ready = 1'b1;
                    regs_nxt.state = PSC_IDLE;
                end
            end
            default: begin
                regs_nxt.state = PSC_POWERUP;
            end
        endcase
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            regs_r <= REGS_RST;
        end else if (enable_in) begin
            regs_r <= regs_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign req_ready_out = regs_r.ready;
    assign rd_valid_out = regs_r.rd_valid;
    assign rd_data_out = regs_r.rd_data;
    assign mem_ready_out = regs_r.mem_ready;
    assign primary_select_n_out = regs_r.sel_n;
    assign secondary_select_out = regs_r.mem_ready;
    assign output_enable_n_out = regs_r.oe_n;
    assign write_strobe_n_out = regs_r.we_n;
    assign upper_lane_select_n_out = regs_r.ub_n;
    assign lower_lane_select_n_out = regs_r.lb_n;
    assign addr_out = regs_r.addr;
    assign dq_out = regs_r.dq;
    assign dq_oe_out = regs_r.dq_oe;
endmodule

// >>> test/psc_host_ctrl_chk.sv
// pin assertions for the pseudo sram host controller
`timescale 1ns/10ps
module psc_host_ctrl_chk #(
    parameter int PWRUP_CYCLES = 20
) (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic mem_ready_out,
    input wire logic primary_select_n_out,
    input wire logic secondary_select_out,
    input wire logic output_enable_n_out,
    input wire logic write_strobe_n_out,
    input wire logic upper_lane_select_n_out,
    input wire logic lower_lane_select_n_out,
    input wire logic dq_oe_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (reset_in);
    logic [15:0] up_r;
    logic [7:0] gap_r;
    logic sel_n_r;
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            up_r <= 16'h0000;
            gap_r <= 8'hff;
            sel_n_r <= 1'b1;
        end else begin
            sel_n_r <= primary_select_n_out;
            if (!mem_ready_out)
                up_r <= up_r + 16'h0001;
            if (sel_n_r && !primary_select_n_out)
                gap_r <= 8'h01;
            else if (gap_r != 8'hff)
                gap_r <= gap_r + 8'h01;
        end
    end
    sequence win_s;
        !primary_select_n_out && !write_strobe_n_out;
    endsequence
    sequence win_open_s;
        $fell(write_strobe_n_out) && !primary_select_n_out;
    endsequence
    pwr_wait_a: assert property (
        $rose(mem_ready_out) |-> up_r >= PWRUP_CYCLES)
        else $error("power-up wait too short");
    pwr_idle_a: assert property (
        !mem_ready_out |-> primary_select_n_out)
        else $error("select low before ready");
    read_lvl_a: assert property (
        !output_enable_n_out |-> !primary_select_n_out && write_strobe_n_out
        && secondary_select_out
        && !(upper_lane_select_n_out && lower_lane_select_n_out))
        else $error("bad read levels");
    cycle_gap_a: assert property (
        $fell(primary_select_n_out) |-> gap_r >= 8'h12)
        else $error("access cycle too short");
    write_lane_a: assert property (
        win_s |-> dq_oe_out
        && !(upper_lane_select_n_out && lower_lane_select_n_out))
        else $error("write window without lane or data");
    write_pulse_a: assert property (
        win_open_s |-> win_s[*8] ##1 win_s[*6])
        else $error("write pulse too short");
    strobe_first_a: assert property (
        $rose(write_strobe_n_out) |-> !primary_select_n_out)
        else $error("select rose before strobe");
endmodule
bind psc_host_ctrl psc_host_ctrl_chk #(.PWRUP_CYCLES(PWRUP_CYCLES)) u_chk (
    .clk_in, .reset_in, .mem_ready_out, .primary_select_n_out,
    .secondary_select_out, .output_enable_n_out, .write_strobe_n_out,
    .upper_lane_select_n_out, .lower_lane_select_n_out, .dq_oe_out);

// >>> test/psc_sram_model.sv
// behavioural pseudo sram on the far side of the controller
`timescale 1ns/10ps
module psc_sram_model #(
    parameter int DLY_NS = 5
) (
    input wire logic sel_n_in,
    input wire logic sec_in,
    input wire logic oe_n_in,
    input wire logic we_n_in,
    input wire logic hi_n_in,
    input wire logic lo_n_in,
    input wire logic [3:0] addr_in,
    input wire logic [15:0] dq_in,
    output logic [15:0] dq_out
);
    logic [15:0] mem [16];
    logic [15:0] junk = 16'h5a5a;
    wire win = !sel_n_in && sec_in && !we_n_in;
    wire rd = !sel_n_in && sec_in && !oe_n_in && we_n_in;
    wire rd_d;
    assign #(DLY_NS) rd_d = rd;
    always #3 junk = ~junk;
    // store when the overlap closes, whichever edge ends it
    always @(negedge win) begin
        if (!hi_n_in) mem[addr_in][15:8] = dq_in[15:8];
        if (!lo_n_in) mem[addr_in][7:0] = dq_in[7:0];
    end
    assign dq_out[15:8] = rd && rd_d && !hi_n_in ? mem[addr_in][15:8]
        : junk[15:8];
    assign dq_out[7:0] = rd && rd_d && !lo_n_in ? mem[addr_in][7:0]
        : junk[7:0];
endmodule

// >>> test/psc_host_ctrl_test.sv
// self-checking bench for the pseudo sram host controller
`timescale 1ns/10ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_total++; \
    $display("wrong value at %0t got %h exp %h", $time, g, e); end end
module psc_host_ctrl_test;
    logic clk_in = 0, reset_in = 1, enable_in = 1, req_valid_in = 0;
    logic req_write_in = 0, req_ready_out, rd_valid_out, mem_ready_out;
    logic [19:0] req_addr_in = '0, addr_out;
    logic [15:0] req_wdata_in = '0, rd_data_out, dq_out, mem_dq, q;
    logic [1:0] req_lane_in = '0;
    logic sel_n, sec, oe_n, we_n, hi_n, lo_n, dq_oe_out;
    int err_total = 0, checked = 0;
    time t0, t1;
    psc_host_ctrl #(.PWRUP_CYCLES(20)) u_psc_host_ctrl (.clk_in, .reset_in,
        .enable_in, .req_valid_in, .req_write_in, .req_addr_in,
        .req_wdata_in, .req_lane_in, .req_ready_out, .rd_valid_out,
        .rd_data_out, .mem_ready_out, .primary_select_n_out(sel_n),
        .secondary_select_out(sec), .output_enable_n_out(oe_n),
        .write_strobe_n_out(we_n), .upper_lane_select_n_out(hi_n),
        .lower_lane_select_n_out(lo_n), .addr_out, .dq_out, .dq_oe_out,
        .dq_in(mem_dq));
    psc_sram_model #(.DLY_NS(70)) u_psc_sram_model (.sel_n_in(sel_n),
        .sec_in(sec), .oe_n_in(oe_n), .we_n_in(we_n), .hi_n_in(hi_n),
        .lo_n_in(lo_n), .addr_in(addr_out[3:0]), .dq_in(dq_out),
        .dq_out(mem_dq));
    task automatic do_req(input logic w, input logic [19:0] a,
            input logic [15:0] d, input logic [1:0] ln);
        int n = 0;
        @(posedge clk_in);
        req_valid_in <= 1'b1;
        req_write_in <= w;
        req_addr_in <= a;
        req_wdata_in <= d;
        req_lane_in <= ln;
        do begin
            @(posedge clk_in);
            n++;
        end while (req_ready_out !== 1'b1 && n < 100);
        t0 = $time;
        req_valid_in <= 1'b0;
        if (req_ready_out !== 1'b1) err_total++;
        n = 0;
        if (!w) begin
            do begin
                @(posedge clk_in);
                n++;
            end while (rd_valid_out !== 1'b1 && n < 100);
            if (rd_valid_out !== 1'b1) err_total++;
            q = rd_data_out;
        end
    endtask
    task automatic t_powerup;
        int n = 0;
        logic hi = 1'b1;
        while (mem_ready_out !== 1'b1 && n < 200) begin
            @(posedge clk_in);
            n++;
            hi &= sel_n;
        end
        `CHK(mem_ready_out, 1'b1)
        `CHK(n >= 20, 1'b1)
        `CHK(hi, 1'b1)
        $display("powerup test done");
    endtask
    task automatic t_lanes;
        logic [1:0] ln [4] = '{2'b11, 2'b01, 2'b10, 2'b00};
        logic [15:0] wd [4] = '{16'h1234, 16'haaab, 16'hcd00, 16'h9876};
        logic [15:0] ex [4] = '{16'h1234, 16'h12ab, 16'hcdab, 16'h9876};
        for (int i = 0; i < 4; i++) begin
            do_req(1'b1, 20'h00003, wd[i], ln[i]);
            enable_in <= 1'b0;
            repeat (3) @(posedge clk_in);
            enable_in <= 1'b1;
            do_req(1'b0, 20'h00003, 16'h0000, 2'b11);
            `CHK(q, ex[i])
        end
        $display("lane test done");
    endtask
    task automatic t_back2back;
        do_req(1'b1, 20'h00005, 16'h0f0f, 2'b11);
        t1 = t0;
        do_req(1'b0, 20'h00005, 16'h0000, 2'b11);
        `CHK(t0 - t1 >= 72, 1'b1)
        `CHK(q, 16'h0f0f)
        $display("back to back test done");
    endtask
    task automatic give_verdict;
        $display("checked %0d wrong %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        forever #2 clk_in = ~clk_in;
    end
    initial begin
        #40000;
        err_total++;
        give_verdict;
    end
    initial begin
        repeat (5) @(posedge clk_in);
        reset_in <= 1'b0;
        t_powerup;
        t_lanes;
        t_back2back;
        give_verdict;
    end
endmodule
